// ### hw/rsc_pkg.sv
// shared constants, types and register map for the reset status controller
package rsc_pkg;
    // register word indices; byte address is four times the index
    localparam logic [5:0] IDX_IRQ_EN = 6'h25;
    localparam logic [5:0] IDX_IRQ_FLAG = 6'h28;
    localparam logic [5:0] IDX_STATUS = 6'h2c;
    localparam logic [5:0] IDX_PWR = 6'h32;
    localparam logic [5:0] IDX_SC0 = 6'h38;
    localparam logic [5:0] IDX_SC1 = 6'h39;
    // reset values
    localparam logic [7:0] RST_IRQ = 8'h00;
    localparam logic [7:0] RST_STAT_BROWNOUT = 8'h80;
    localparam logic [7:0] RST_STAT_PIN = 8'h08;
    localparam logic [7:0] RST_PWR = 8'h80;
    localparam logic [7:0] RST_SC0 = 8'h80;
    localparam logic [7:0] RST_SC1 = 8'h03;
    // status bit positions
    localparam int ST_BROWNOUT = 7;
    localparam int ST_SLEEP = 6;
    localparam int ST_WDOG = 5;
    localparam int ST_IDLE = 4;
    localparam int ST_PIN = 3;
    localparam int ST_STACK = 2;
    localparam int ST_SUPPLY_LOW = 1;
    localparam int ST_I2C = 0;
    localparam logic [7:0] ST_W0_MASK = 8'hfd;
    // control bit positions and masks
    localparam int PWR_UNLOCK = 0;
    localparam logic [7:0] PWR_RD_MASK = 8'hf9;
    localparam logic [7:0] PWR_ISR_CLR = 8'h06;
    localparam int SC0_STACK_EN = 7;
    localparam logic [7:0] SC0_MASK = 8'h80;
    localparam int SC1_TH_LSB = 2;
    localparam int SC1_ACTION = 1;
    localparam int SC1_ENABLE = 0;
    localparam logic [7:0] SC1_MASK = 8'h1f;
    localparam logic [7:0] IEN_MASK = 8'h7f;
    localparam int IRQ_SUPPLY = 0;
    // start-up wait, in oscillator cycles per phase
    localparam int OSC_CYCLES = 1024;
    localparam logic [9:0] OSC_LAST = 10'(OSC_CYCLES - 1);
    localparam logic [15:0] RESET_VECTOR = 16'h0000;

    typedef enum logic [1:0] {
        SEQ_HOLD = 2'b00,
        SEQ_SLOW = 2'b01,
        SEQ_FAST = 2'b11,
        SEQ_RUN = 2'b10
    } rsc_seq_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } rsc_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } rsc_wb_rsp_t;

    typedef struct packed {
        logic extRstN;
        logic basicLow;
        logic preciseLow;
        logic watchdog;
        logic stackFault;
        logic sleepExec;
        logic idleExec;
        logic i2cResetCmd;
    } rsc_evt_t;

    localparam rsc_evt_t EVT_IDLE = 8'h80;

    typedef struct packed {
        logic hold;
        logic partial;
        logic fetchStart;
        logic [15:0] fetchAddr;
    } rsc_cpu_t;

    typedef struct packed {
        rsc_seq_t st;
        logic [9:0] cnt;
        rsc_wb_rsp_t rsp;
        rsc_cpu_t cpu;
        logic irqReq;
        logic [7:0] ien;
        logic [7:0] ifl;
        logic [7:0] stat;
        logic [7:0] pwr;
        logic [7:0] sc0;
        logic [7:0] sc1;
    } rsc_state_t;

    localparam rsc_state_t RST_STATE = '{
        st: SEQ_HOLD, cnt: 10'h000, rsp: '0,
        cpu: '{hold: 1'b1, partial: 1'b0, fetchStart: 1'b0, fetchAddr: RESET_VECTOR},
        irqReq: 1'b0, ien: RST_IRQ, ifl: RST_IRQ, stat: RST_STAT_BROWNOUT,
        pwr: RST_PWR, sc0: RST_SC0, sc1: RST_SC1};
endpackage

// ### hw/rsc_sync.sv
// two-stage synchroniser for the reset pin and detector/event inputs
`timescale 1ns/1ps
module rsc_sync
    import rsc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // raw and synchronised events
    input wire rsc_evt_t evtIn,
    output rsc_evt_t evtOut
);
    typedef struct packed {
        rsc_evt_t meta;
        rsc_evt_t out;
    } rsc_sync_state_t;

    rsc_sync_state_t s_q;
    rsc_sync_state_t s_d;

    // first stage feeds only the second stage
    always_comb begin
        s_d.meta = evtIn;
        s_d.out = s_q.meta;
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            s_q <= '{meta: EVT_IDLE, out: EVT_IDLE};
        end else begin
            s_q <= s_d;
        end
    end

    assign evtOut = s_q.out;
endmodule

// ### hw/rsc_reset_ctrl.sv
// reset sequencer, reset cause status and supply detector control
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps
module rsc_reset_ctrl
    import rsc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // register bus
    input wire rsc_wb_req_t wbReq,
    output rsc_wb_rsp_t wbRsp,
    // reset sources and cpu events
    input wire rsc_evt_t evtRaw,
    // oscillator ticks
    input wire logic slowOscTick,
    input wire logic fastOscTick,
    // cpu side
    output rsc_cpu_t cpuCtl,
    // detector control and interrupt request
    output logic [2:0] supplyThresholdSelect,
    output logic preciseDetectorEnable,
    output logic supplyIrqReq
);
    rsc_evt_t ev;
    rsc_state_t s_q;
    rsc_state_t s_d;
    logic preciseTrip;
    logic hwSrc;
    logic swReset;
    logic acc;
    logic wrEn;
    logic unlocked;
    logic [5:0] idx;
    logic [7:0] wdat;
    logic [7:0] rdat;

    rsc_sync i_rsc_sync (
        .clock(clock),
        .rst_b(rst_b),
        .evtIn(evtRaw),
        .evtOut(ev)
    );

    always_comb begin
        preciseTrip = ev.preciseLow && s_q.sc1[SC1_ENABLE] && s_q.sc1[SC1_ACTION];
        hwSrc = ev.basicLow || !ev.extRstN || preciseTrip;
        swReset = ev.watchdog || (ev.stackFault && s_q.sc0[SC0_STACK_EN]);
        acc = wbReq.cyc && wbReq.stb && !s_q.rsp.ack;
        // writes commit at the edge where the master samples ack, not when first seen
        wrEn = wbReq.cyc && wbReq.stb && s_q.rsp.ack && wbReq.we && wbReq.sel[0];
        unlocked = s_q.pwr[PWR_UNLOCK];
        idx = wbReq.adr[7:2];
        wdat = wbReq.dat[7:0];
    end

    // read mux; unmapped words read zero
    always_comb begin
        rdat = 8'h00;
        unique case (idx)
            IDX_IRQ_EN: rdat = s_q.ien;
            IDX_IRQ_FLAG: rdat = s_q.ifl;
            IDX_STATUS: begin
                rdat = s_q.stat;
                rdat[ST_SUPPLY_LOW] = ev.preciseLow && s_q.sc1[SC1_ENABLE];
            end
            IDX_PWR: rdat = s_q.pwr & PWR_RD_MASK;
            IDX_SC0: rdat = s_q.sc0;
            IDX_SC1: rdat = s_q.sc1;
            default: rdat = 8'h00;
        endcase
    end

    always_comb begin
        s_d = s_q;
        s_d.rsp.ack = acc;
        s_d.cpu.partial = 1'b0;
        s_d.cpu.fetchStart = 1'b0;
        s_d.cpu.fetchAddr = RESET_VECTOR;
        if (acc) begin
            s_d.rsp.dat = {24'h000000, rdat};
        end
        // register writes; hardware events below win over them
        if (wrEn) begin
            unique case (idx)
                IDX_IRQ_EN: s_d.ien = wdat & IEN_MASK;
                IDX_IRQ_FLAG: s_d.ifl = wdat;
                IDX_STATUS: s_d.stat = s_q.stat & (wdat | ~ST_W0_MASK);
                IDX_PWR: s_d.pwr = wdat;
                IDX_SC0: begin
                    if (unlocked) begin
                        s_d.sc0 = wdat & SC0_MASK;
                    end
                end
                IDX_SC1: begin
                    if (unlocked) begin
                        s_d.sc1 = wdat & SC1_MASK;
                    end
                end
                default: s_d.ien = s_d.ien;
            endcase
        end
        // sticky event flags: set wins over a same-cycle clear
        if (ev.sleepExec) begin
            s_d.stat[ST_SLEEP] = 1'b1;
        end
        if (ev.idleExec) begin
            s_d.stat[ST_IDLE] = 1'b1;
        end
        if (ev.i2cResetCmd) begin
            s_d.stat[ST_I2C] = 1'b1;
        end
        if (ev.preciseLow && s_q.sc1[SC1_ENABLE] && !s_q.sc1[SC1_ACTION]) begin
            s_d.ifl[IRQ_SUPPLY] = 1'b1;
        end
        s_d.irqReq = s_d.ifl[IRQ_SUPPLY] && s_d.ien[IRQ_SUPPLY];
        // start-up sequencer
        unique case (s_q.st)
            SEQ_HOLD: begin
                s_d.cnt = 10'h000;
                s_d.st = SEQ_SLOW;
            end
            SEQ_SLOW: begin
                if (slowOscTick) begin
                    if (s_q.cnt == OSC_LAST) begin
                        s_d.cnt = 10'h000;
                        s_d.st = SEQ_FAST;
                    end else begin
                        s_d.cnt = s_q.cnt + 10'h001;
                    end
                end
            end
            SEQ_FAST: begin
                if (fastOscTick) begin
                    if (s_q.cnt == OSC_LAST) begin
                        s_d.cnt = 10'h000;
                        s_d.st = SEQ_RUN;
                        s_d.cpu.hold = 1'b0;
                        s_d.cpu.fetchStart = 1'b1;
                    end else begin
                        s_d.cnt = s_q.cnt + 10'h001;
                    end
                end
            end
            SEQ_RUN: begin
                // soft reset: no start-up wait, cpu keeps running
                if (swReset) begin
                    s_d.cpu.partial = 1'b1;
                    s_d.cpu.fetchStart = 1'b1;
                    s_d.pwr = s_d.pwr & ~PWR_ISR_CLR;
                    if (ev.watchdog) begin
                        s_d.stat[ST_WDOG] = 1'b1;
                    end
                    if (ev.stackFault && s_q.sc0[SC0_STACK_EN]) begin
                        s_d.stat[ST_STACK] = 1'b1;
                    end
                end
            end
        endcase
        // hardware reset overrides everything except the bus response while a source is active
        if (hwSrc) begin
            s_d.st = SEQ_HOLD;
            s_d.cnt = 10'h000;
            s_d.cpu.hold = 1'b1;
            s_d.cpu.partial = 1'b0;
            s_d.cpu.fetchStart = 1'b0;
            s_d.ien = RST_IRQ;
            s_d.ifl = RST_IRQ;
            s_d.irqReq = 1'b0;
            s_d.pwr = RST_PWR;
            s_d.sc0 = RST_SC0;
            s_d.sc1 = RST_SC1;
            if (ev.basicLow || preciseTrip) begin
                s_d.stat = RST_STAT_BROWNOUT;
            end else begin
                s_d.stat = RST_STAT_PIN;
            end
            if (ev.basicLow) begin
                s_d.sc1[SC1_ENABLE] = 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            s_q <= RST_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    assign wbRsp = s_q.rsp;
    assign cpuCtl = s_q.cpu;
    assign supplyThresholdSelect = s_q.sc1[SC1_TH_LSB +: 3];
    assign preciseDetectorEnable = s_q.sc1[SC1_ENABLE];
    assign supplyIrqReq = s_q.irqReq;

    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    property p_bo_hold;
        ev.basicLow |=> s_q.cpu.hold && s_q.st == SEQ_HOLD;
    endproperty
    a_bo_hold: assert property (p_bo_hold) else $error("brown-out did not hold cpu");

    property p_bo_flag;
        ev.basicLow |=> s_q.stat == RST_STAT_BROWNOUT;
    endproperty
    a_bo_flag: assert property (p_bo_flag) else $error("brown-out status wrong");

    property p_pin_flag;
        (!ev.extRstN && !ev.basicLow && !preciseTrip) |=> s_q.stat == RST_STAT_PIN;
    endproperty
    a_pin_flag: assert property (p_pin_flag) else $error("pin reset status wrong");

    property p_run_entry;
        (s_q.st == SEQ_RUN && $past(s_q.st) != SEQ_RUN) |->
            $past(s_q.st) == SEQ_FAST && $past(s_q.cnt) == OSC_LAST && s_q.cpu.fetchStart && !s_q.cpu.hold;
    endproperty
    a_run_entry: assert property (p_run_entry) else $error("run entered early");

    property p_fast_entry;
        (s_q.st == SEQ_FAST && $past(s_q.st) == SEQ_SLOW) |-> $past(s_q.cnt) == OSC_LAST;
    endproperty
    a_fast_entry: assert property (p_fast_entry) else $error("slow phase too short");

    property p_wdog;
        (ev.watchdog && !hwSrc && s_q.st == SEQ_RUN) |=>
            s_q.cpu.partial && !s_q.cpu.hold && s_q.stat[ST_WDOG] && s_q.cpu.fetchAddr == RESET_VECTOR;
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog reset wrong");

    property p_stack_gate;
        (ev.stackFault && !ev.watchdog && !s_q.sc0[SC0_STACK_EN] && !hwSrc) |=> !s_q.cpu.partial;
    endproperty
    a_stack_gate: assert property (p_stack_gate) else $error("gated stack fault reset");

    property p_locked;
        (wrEn && idx == IDX_SC1 && !s_q.pwr[PWR_UNLOCK] && !hwSrc) |=> $stable(s_q.sc1);
    endproperty
    a_locked: assert property (p_locked) else $error("locked write took effect");

    property p_sleep;
        (ev.sleepExec && !hwSrc) |=> s_q.stat[ST_SLEEP];
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep flag not set");

    property p_supply_irq;
        (ev.preciseLow && s_q.sc1[SC1_ENABLE] && !s_q.sc1[SC1_ACTION] && !hwSrc) |=>
            s_q.ifl[IRQ_SUPPLY] && (s_q.irqReq == s_q.ien[IRQ_SUPPLY]);
    endproperty
    a_supply_irq: assert property (p_supply_irq) else $error("supply interrupt flag missing");

    property p_pin_hold;
        !ev.extRstN |=> s_q.cpu.hold && s_q.st == SEQ_HOLD;
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("pin reset did not hold cpu");

    property p_trip_reset;
        preciseTrip |=> s_q.cpu.hold && s_q.stat == RST_STAT_BROWNOUT;
    endproperty
    a_trip_reset: assert property (p_trip_reset) else $error("precise trip did not reset");

    property p_stack_flag;
        (ev.stackFault && s_q.sc0[SC0_STACK_EN] && !hwSrc && s_q.st == SEQ_RUN) |=> s_q.cpu.partial && s_q.stat[ST_STACK];
    endproperty
    a_stack_flag: assert property (p_stack_flag) else $error("stack fault reset wrong");

    property p_idle;
        (ev.idleExec && !hwSrc) |=> s_q.stat[ST_IDLE];
    endproperty
    a_idle: assert property (p_idle) else $error("idle flag not set");

    property p_i2c;
        (ev.i2cResetCmd && !hwSrc) |=> s_q.stat[ST_I2C];
    endproperty
    a_i2c: assert property (p_i2c) else $error("command flag not set");

    property p_soft_keeps_sc1;
        (swReset && !hwSrc && !wrEn) |=> $stable(s_q.sc1);
    endproperty
    a_soft_keeps_sc1: assert property (p_soft_keeps_sc1) else $error("soft reset changed control one");

    property p_status_clear;
        (wrEn && idx == IDX_STATUS && wdat == 8'h00 && !hwSrc && !swReset && !ev.sleepExec && !ev.idleExec
            && !ev.i2cResetCmd) |=> s_q.stat == 8'h00;
    endproperty
    a_status_clear: assert property (p_status_clear) else $error("status zero write did not clear");

    property p_hold_release;
        $fell(s_q.cpu.hold) |-> s_q.cpu.fetchStart && s_q.st == SEQ_RUN;
    endproperty
    a_hold_release: assert property (p_hold_release) else $error("hold fell outside run entry");

    property p_pwr_soft;
        (swReset && s_q.st == SEQ_RUN && !hwSrc) |=> (s_q.pwr & PWR_ISR_CLR) == 8'h00;
    endproperty
    a_pwr_soft: assert property (p_pwr_soft) else $error("soft reset kept power bits");

    property p_slow_count;
        (s_q.st == SEQ_SLOW && slowOscTick && s_q.cnt != OSC_LAST && !hwSrc) |=>
            s_q.st == SEQ_SLOW && s_q.cnt == $past(s_q.cnt) + 10'h001;
    endproperty
    a_slow_count: assert property (p_slow_count) else $error("slow count skipped");

    property p_locked_sc0;
        (wrEn && idx == IDX_SC0 && !s_q.pwr[PWR_UNLOCK] && !hwSrc) |=> $stable(s_q.sc0);
    endproperty
    a_locked_sc0: assert property (p_locked_sc0) else $error("locked control zero write took effect");

    property p_partial_no_hold;
        s_q.cpu.partial |-> !s_q.cpu.hold;
    endproperty
    a_partial_no_hold: assert property (p_partial_no_hold) else $error("partial reset while held");

    property p_fetch_addr;
        s_q.cpu.fetchStart |-> s_q.cpu.fetchAddr == RESET_VECTOR;
    endproperty
    a_fetch_addr: assert property (p_fetch_addr) else $error("fetch not from address zero");

    // trip and pin paths are the ones a quick test tends to skip
    c_trip_reset: cover property (preciseTrip);
    c_pin_reset: cover property (!ev.extRstN ##1 s_q.cpu.hold);
    c_full_start: cover property (s_q.st == SEQ_FAST ##1 s_q.st == SEQ_RUN);
    c_partial: cover property (s_q.cpu.partial && s_q.stat[ST_STACK]);
    c_unlock_write: cover property (wrEn && idx == IDX_SC1 && s_q.pwr[PWR_UNLOCK]);
endmodule

// ### testbench/rsc_far_side.sv
// far-side model: oscillator ticks plus core, watchdog, pin and supply events
`timescale 1ns/1ps
module rsc_far_side
    import rsc_pkg::*;
(
    // clock
    input wire logic clock,
    // bench commands
    input wire rsc_evt_t evtCmd,
    input wire logic [1:0] tickGap,
    // device side
    input wire rsc_cpu_t cpuCtl,
    output rsc_evt_t evtRaw,
    output logic slowOscTick,
    output logic fastOscTick
);
    logic [1:0] gapCnt = 2'h0;
    always @(posedge clock) begin
        gapCnt <= (gapCnt >= tickGap) ? 2'h0 : gapCnt + 2'h1;
    end
    // gap 0 ticks every cycle, larger gaps model slow oscillators
    assign slowOscTick = (gapCnt == 2'h0);
    assign fastOscTick = (gapCnt == 2'h0);
    // a held core executes nothing, so it raises no soft events
    always_comb begin
        evtRaw = evtCmd;
        if (cpuCtl.hold !== 1'b0) begin
            evtRaw.watchdog = 1'b0;
            evtRaw.stackFault = 1'b0;
            evtRaw.sleepExec = 1'b0;
            evtRaw.idleExec = 1'b0;
        end
    end
endmodule

// ### testbench/reset_status_and_brownout_control_test.sv
// self-checking bench for the reset status controller
`timescale 1ns/1ps
module reset_status_and_brownout_control_test
    import rsc_pkg::*;
;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    rsc_wb_req_t wbReq = '0;
    rsc_wb_rsp_t wbRsp;
    rsc_evt_t evtCmd = EVT_IDLE;
    rsc_evt_t evtRaw;
    logic [1:0] tickGap = 2'h0;
    logic slowOscTick;
    logic fastOscTick;
    rsc_cpu_t cpuCtl;
    logic [2:0] supplyThresholdSelect;
    logic preciseDetectorEnable;
    logic supplyIrqReq;
    int fails = 0;
    int num_checks = 0;
    int n;
    logic [8:0] expQ[$];
    logic [8:0] monE;
    logic [31:0] seed = 32'h0156;

    always #2.5 clock = ~clock;

    rsc_reset_ctrl i_rsc_reset_ctrl(.clock(clock), .rst_b(rst_b), .wbReq(wbReq), .wbRsp(wbRsp),
        .evtRaw(evtRaw), .slowOscTick(slowOscTick), .fastOscTick(fastOscTick), .cpuCtl(cpuCtl),
        .supplyThresholdSelect(supplyThresholdSelect), .preciseDetectorEnable(preciseDetectorEnable),
        .supplyIrqReq(supplyIrqReq));
    rsc_far_side i_rsc_far_side(.clock(clock), .evtCmd(evtCmd), .tickGap(tickGap), .cpuCtl(cpuCtl),
        .evtRaw(evtRaw), .slowOscTick(slowOscTick), .fastOscTick(fastOscTick));

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic final_report();
        if (fails == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // classic single cycle; read expectations go to the monitor's queue
    task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d, input logic [7:0] e);
        expQ.push_back({~w, e});
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'h1, adr: {idx, 2'b00}, dat: {24'h0, d}};
        do @(posedge clock); while (wbRsp.ack !== 1'b1);
        wbReq <= '0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        wb(1'b1, idx, d, 8'h00);
    endtask

    task automatic rd(input logic [5:0] idx, input logic [7:0] e);
        wb(1'b0, idx, 8'h00, e);
    endtask

    task automatic pulse(input logic [7:0] m);
        evtCmd <= EVT_IDLE | m;
        @(posedge clock);
        evtCmd <= EVT_IDLE;
        // two more edges so the synchronised event has landed before the next read
        repeat (2) @(posedge clock);
    endtask

    task automatic waitRun(input int least);
        n = 0;
        while (cpuCtl.hold !== 1'b0 && n < 20000) begin
            @(posedge clock);
            n++;
        end
        chk("startup long enough", 16'h1, 16'(n >= least));
        chk("fetch start", 16'h1, 16'(cpuCtl.fetchStart));
        chk("fetch address", RESET_VECTOR, cpuCtl.fetchAddr);
    endtask

    task automatic softWait();
        n = 0;
        while (cpuCtl.partial !== 1'b1 && n < 10) begin
            @(posedge clock);
            n++;
        end
        chk("partial reset", 16'h1, 16'(cpuCtl.partial));
        chk("no full hold", 16'h0, 16'(cpuCtl.hold));
        chk("restart fetch", 16'h1, 16'(cpuCtl.fetchStart));
    endtask

    always @(posedge clock) begin
        if (wbRsp.ack === 1'b1 && expQ.size() > 0) begin
            monE = expQ.pop_front();
            if (monE[8]) begin
                chk("read data", {8'h00, monE[7:0]}, wbRsp.dat[15:0]);
            end
        end
    end

    initial begin
        #200000;
        fails++;
        final_report();
    end

    initial begin
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        waitRun(2048);
        rd(IDX_STATUS, 8'h80);
        rd(IDX_PWR, 8'h80);
        rd(IDX_SC0, 8'h80);
        rd(IDX_SC1, 8'h03);
        rd(IDX_IRQ_EN, 8'h00);
        rd(IDX_IRQ_FLAG, 8'h00);
        rd(6'h10, 8'h00);
        wr(IDX_SC1, 8'h1c);
        rd(IDX_SC1, 8'h03);
        wr(IDX_PWR, 8'h81);
        rd(IDX_PWR, 8'h81);
        for (int i = 0; i < 3; i++) begin
            seed = xorshift(seed);
            wr(IDX_SC1, seed[7:0]);
            rd(IDX_SC1, seed[7:0] & SC1_MASK);
            chk("threshold", 16'(seed[4:2]), 16'(supplyThresholdSelect));
            chk("detector enable", 16'(seed[0]), 16'(preciseDetectorEnable));
        end
        wr(IDX_SC1, 8'h01);
        wr(IDX_STATUS, 8'h00);
        rd(IDX_STATUS, 8'h00);
        pulse(8'h07);
        rd(IDX_STATUS, 8'h51);
        wr(IDX_STATUS, 8'h00);
        rd(IDX_STATUS, 8'h00);
        // supply dip handled as interrupt with action bit clear
        evtCmd <= EVT_IDLE | 8'h20;
        repeat (4) @(posedge clock);
        rd(IDX_STATUS, 8'h02);
        rd(IDX_IRQ_FLAG, 8'h01);
        wr(IDX_IRQ_EN, 8'h01);
        chk("supply irq", 16'h1, 16'(supplyIrqReq));
        evtCmd <= EVT_IDLE;
        repeat (4) @(posedge clock);
        wr(IDX_IRQ_FLAG, 8'h00);
        @(posedge clock);
        chk("supply irq cleared", 16'h0, 16'(supplyIrqReq));
        pulse(8'h10);
        softWait();
        rd(IDX_STATUS, 8'h20);
        rd(IDX_SC1, 8'h01);
        wr(IDX_PWR, 8'h81);
        wr(IDX_SC0, 8'h00);
        pulse(8'h08);
        repeat (10) @(posedge clock);
        rd(IDX_STATUS, 8'h20);
        wr(IDX_SC0, 8'h80);
        pulse(8'h08);
        softWait();
        rd(IDX_STATUS, 8'h24);
        // pin reset with slow oscillators
        tickGap <= 2'h3;
        evtCmd <= 8'h00;
        repeat (6) @(posedge clock);
        chk("pin hold", 16'h1, 16'(cpuCtl.hold));
        evtCmd <= EVT_IDLE;
        waitRun(8000);
        rd(IDX_STATUS, 8'h08);
        rd(IDX_SC1, 8'h03);
        wr(IDX_SC0, 8'h00);
        rd(IDX_SC0, 8'h80);
        tickGap <= 2'h0;
        evtCmd <= EVT_IDLE | 8'h40;
        repeat (200) @(posedge clock);
        chk("brownout hold", 16'h1, 16'(cpuCtl.hold));
        evtCmd <= EVT_IDLE;
        waitRun(2048);
        rd(IDX_STATUS, 8'h80);
        rd(IDX_SC1, 8'h03);
        // precise trip with the default reset action
        evtCmd <= EVT_IDLE | 8'h20;
        repeat (6) @(posedge clock);
        chk("trip hold", 16'h1, 16'(cpuCtl.hold));
        evtCmd <= EVT_IDLE;
        waitRun(2048);
        rd(IDX_STATUS, 8'h80);
        final_report();
    end
endmodule
